// ### hdl/ufcc_core.sv
// control register block of a usb function core
`timescale 1ns/1ps
`default_nettype none
`include "ufcc_regs.svh"

// Function
// - host_disconnect 0 connects pull-up, 1 disconnects
// - bus reset ignored while disconnected
// - usb_clock_stop 1 gates usb clock
// - clock stop and soft reset clear together
// - auto-clear select lets clear feature unstall
// - reserved control bit 2 reads zero
// - interrupt toggle: success only, or always
// - power source reported for get status
// - ep0 stall write one stalls, zero ignored
// - ep0 stall cleared by setup after stall
// - ep0 stall reads as zero
// - ep0 upper bits ignored, reserved read zero
// - seven-bit ep0 packet size, resets to 64, written values not limited to 64
// - soft reset ored with chip reset, resets one
module ufcc_core (
  input wire logic sys_clk_i, // 40 MHz system clock
  input wire logic rst_i, // chip reset, synchronous, active high
  input wire logic clk_en_i, // freezes all state while low
  // avalon-mm slave
  input wire logic [3:0] avs_address_i, // byte address
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // usb protocol side events, one-cycle pulses
  input wire logic usb_bus_reset_i, // bus reset seen on the line
  input wire logic ep0_stall_sent_i, // ep0 handshake was stall
  input wire logic ep0_setup_rx_i, // setup packet on ep0
  input wire logic clear_feature_i, // clear feature halt received
  input wire logic [2:0] clear_feature_ep_i, // endpoint it names
  input wire logic [5:1] epn_stall_set_i, // software stall request ep1..5
  input wire logic [5:1] epn_stall_clr_i, // software stall release ep1..5
  input wire logic intr_done_i, // interrupt transfer ended
  input wire logic intr_ok_i, // it ended successfully
  // control outputs
  output logic pullup_en_o, // closes pull-up switch
  output logic clk_gate_en_o, // usb operating clock runs
  output logic core_reset_o, // usb function reset
  output logic bus_reset_ok_o, // bus reset accepted by core
  output logic ep0_stall_o, // ep0 answers with stall
  output logic [5:1] epn_stall_o, // ep1..5 answer with stall
  output logic intr_toggle_o, // current interrupt data pid
  output logic self_powered_o, // get status self powered bit
  output logic [6:0] ep0_max_packet_o // ep0 packet size in bytes
);

  // ==========================================================
  // state
  ufcc_pkg::ufcc_state_s state_r; // all flops of the block
  ufcc_pkg::ufcc_state_s state_nxt; // next value
  // one struct for all flops keeps the clock enable and reset in a single place

  // decode a byte address into a word hit; used for read and write
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] b);
    addr_hit = (a == b);
  endfunction

  // ==========================================================
  // next state logic
  always_comb begin
    logic wr_cc; // write strobe for core_control low byte
    logic wr_ep; // write strobe for endpoint_zero_control
    logic wr_bi; // write strobe for buffer init flags
    logic ep_lo; // low byte lane of ep0 register
    logic ep_hi; // high byte lane of ep0 register
    logic in_reset; // chip or soft reset in force
    wr_cc = 1'b0;
    wr_ep = 1'b0;
    wr_bi = 1'b0;
    ep_lo = avs_byteenable_i[0];
    ep_hi = avs_byteenable_i[1];
    in_reset = 1'b0;
    state_nxt = state_r;

    // bus slave: request taken in idle, answered one cycle later
    case (state_r.bus)
      ufcc_pkg::UFCC_BUS_IDLE: begin
        // a request is taken only here, so a held request is never taken twice
        state_nxt.waitreq = 1'b1;
        if (avs_read_i || avs_write_i) begin
          state_nxt.bus = ufcc_pkg::UFCC_BUS_ANSWER;
          state_nxt.waitreq = 1'b0;
          // lane 0 carries bits 7:0 of every register, lane 1 bits 15:8
          wr_cc = avs_write_i && avs_byteenable_i[0] &&
                  addr_hit(avs_address_i, `UFCC_CORE_CONTROL_ADDR);
          wr_ep = avs_write_i && addr_hit(avs_address_i, `UFCC_EP_ZERO_CONTROL_ADDR);
          wr_bi = avs_write_i && avs_byteenable_i[0] &&
                  addr_hit(avs_address_i, `UFCC_BUF_INIT_ADDR);
          state_nxt.rdata = 16'h0000; // unmapped and reserved read zero
          if (addr_hit(avs_address_i, `UFCC_CORE_CONTROL_ADDR)) begin
            // reserved bit 2 and bits 15:8 stay zero
            state_nxt.rdata[`UFCC_CC_SOFT_RESET] = state_r.ctrl.soft_reset;
            state_nxt.rdata[`UFCC_CC_HOST_DISCONNECT] = state_r.ctrl.host_disconnect;
            state_nxt.rdata[`UFCC_CC_USB_CLOCK_STOP] = state_r.ctrl.usb_clock_stop;
            state_nxt.rdata[`UFCC_CC_STALL_AUTO_CLEAR] =
              state_r.ctrl.stall_auto_clear_select;
            state_nxt.rdata[`UFCC_CC_TOGGLE_MODE] = state_r.ctrl.toggle_mode_select;
            state_nxt.rdata[`UFCC_CC_POWER_SOURCE] = state_r.ctrl.power_source_select;
          end else if (addr_hit(avs_address_i, `UFCC_EP_ZERO_CONTROL_ADDR)) begin
            // stall always reads zero so write-back never sets it
            // upper nibble read as zero, reserved bits zero
            state_nxt.rdata[`UFCC_EP0_PKS_MSB:0] = state_r.ep0_pks;
          end else if (addr_hit(avs_address_i, `UFCC_BUF_INIT_ADDR)) begin
            state_nxt.rdata[`UFCC_BI_EP0] = state_r.buf_init_ep0;
          end
        end
      end
      ufcc_pkg::UFCC_BUS_ANSWER: begin
        // answer stands one cycle, then back to waiting
        state_nxt.bus = ufcc_pkg::UFCC_BUS_IDLE;
        state_nxt.waitreq = 1'b1;
      end
      default: begin
        // unused state codes fall back to idle
        state_nxt.bus = ufcc_pkg::UFCC_BUS_IDLE;
        state_nxt.waitreq = 1'b1;
      end
    endcase

    // core_control write; clock stop and reset may clear together
    if (wr_cc) begin
      state_nxt.ctrl.soft_reset = avs_writedata_i[`UFCC_CC_SOFT_RESET];
      state_nxt.ctrl.usb_clock_stop = avs_writedata_i[`UFCC_CC_USB_CLOCK_STOP];
      // settings below take effect only while soft reset is held
      // trade-off: a late write is dropped silently rather than flagged
      if (state_r.ctrl.soft_reset) begin
        state_nxt.ctrl.host_disconnect = avs_writedata_i[`UFCC_CC_HOST_DISCONNECT];
        state_nxt.ctrl.stall_auto_clear_select =
          avs_writedata_i[`UFCC_CC_STALL_AUTO_CLEAR];
        state_nxt.ctrl.toggle_mode_select = avs_writedata_i[`UFCC_CC_TOGGLE_MODE];
        state_nxt.ctrl.power_source_select = avs_writedata_i[`UFCC_CC_POWER_SOURCE];
      end
    end

    // soft reset sets the ep0 buffer init flag; software clears it afterwards
    // limitation: only the ep0 flag lives here, other endpoints keep their own
    if (wr_bi && !avs_writedata_i[`UFCC_BI_EP0]) begin
      state_nxt.buf_init_ep0 = 1'b0;
    end
    if (state_r.ctrl.soft_reset) begin
      state_nxt.buf_init_ep0 = 1'b1;
    end

    // ep0 packet size only during init; undefined nibble dropped
    if (wr_ep && ep_lo && state_r.ctrl.soft_reset && state_r.buf_init_ep0) begin
      state_nxt.ep0_pks = avs_writedata_i[`UFCC_EP0_PKS_MSB:0];
    end

    // ep0 stall: record that a stall went out, setup then releases
    if (state_r.ep0_stall && ep0_stall_sent_i) begin
      state_nxt.ep0_stall_sent = 1'b1;
    end
    if (state_r.ep0_stall_sent && ep0_setup_rx_i) begin
      state_nxt.ep0_stall = 1'b0;
      state_nxt.ep0_stall_sent = 1'b0;
    end
    // a write of one wins over the hardware clear; zero is ignored
    if (wr_ep && ep_hi && avs_writedata_i[`UFCC_EP0_STALL]) begin
      state_nxt.ep0_stall = 1'b1;
      state_nxt.ep0_stall_sent = 1'b0;
    end

    // ep1..5 stall: hardware release only in auto-clear mode
    // ep0 is handled above, so the loop starts at endpoint one
    for (int i = 1; i <= 5; i++) begin
      if (state_r.ctrl.stall_auto_clear_select) begin
        if (clear_feature_i && clear_feature_ep_i == 3'(i)) begin
          state_nxt.epn_stall[i] = 1'b0;
        end
      end else if (epn_stall_clr_i[i]) begin
        state_nxt.epn_stall[i] = 1'b0;
      end
      if (epn_stall_set_i[i]) begin
        state_nxt.epn_stall[i] = 1'b1; // set wins over clear
      end
    end

    // interrupt data pid toggle
    // mode 1 flips even after a failed transfer; the host must follow suit
    if (intr_done_i && (state_r.ctrl.toggle_mode_select || intr_ok_i)) begin
      state_nxt.intr_toggle = ~state_r.intr_toggle;
    end

    // registered outputs
    // taken from the next state, bar bus_reset_ok, so outputs move on the write edge itself
    in_reset = state_nxt.ctrl.soft_reset;
    state_nxt.core_reset = in_reset;
    state_nxt.pullup_en = ~state_nxt.ctrl.host_disconnect;
    state_nxt.clk_gate_en = ~state_nxt.ctrl.usb_clock_stop;
    state_nxt.bus_reset_ok = usb_bus_reset_i && !state_r.ctrl.host_disconnect;
    state_nxt.ep0_stall_active = state_nxt.ep0_stall;
    state_nxt.epn_stall_active = state_nxt.epn_stall;
    state_nxt.self_powered = state_nxt.ctrl.power_source_select;
    if (in_reset) begin
      state_nxt.intr_toggle = 1'b0; // data pid restarts at data0
    end
  end

  // ==========================================================
  // state register; chip reset forces soft reset high
  // chip reset wins over the enable, so reset needs no running enable
  // enable low freezes everything, a pending bus answer too
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= '0;
      state_r.bus <= ufcc_pkg::UFCC_BUS_IDLE;
      state_r.waitreq <= 1'b1;
      state_r.ctrl.soft_reset <= 1'b1;
      state_r.ctrl.host_disconnect <= 1'b1;
      state_r.ep0_pks <= `UFCC_EP0_PKS_RESET;
      state_r.buf_init_ep0 <= 1'b1;
      state_r.core_reset <= 1'b1;
      state_r.clk_gate_en <= 1'b1;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops
  // the upper read half is constant zero: all three registers are 16 bits wide
  assign avs_readdata_o = {16'h0000, state_r.rdata};
  assign avs_waitrequest_o = state_r.waitreq;
  assign pullup_en_o = state_r.pullup_en;
  assign clk_gate_en_o = state_r.clk_gate_en;
  assign core_reset_o = state_r.core_reset;
  assign bus_reset_ok_o = state_r.bus_reset_ok;
  assign ep0_stall_o = state_r.ep0_stall_active;
  assign epn_stall_o = state_r.epn_stall_active;
  assign intr_toggle_o = state_r.intr_toggle;
  assign self_powered_o = state_r.self_powered;
  assign ep0_max_packet_o = state_r.ep0_pks;

  // ==========================================================
  // assertions
  // every check runs on the one clock and stays quiet during chip reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // helpers: a write taken at this edge; waitrequest high means the slave is idle
  logic cc_take; // core_control low byte write accepted
  logic ep_take; // endpoint_zero_control write accepted
  assign cc_take = clk_en_i && avs_write_i && avs_waitrequest_o && avs_byteenable_i[0] &&
    (avs_address_i == `UFCC_CORE_CONTROL_ADDR);
  assign ep_take = clk_en_i && avs_write_i && avs_waitrequest_o &&
    (avs_address_i == `UFCC_EP_ZERO_CONTROL_ADDR);

  // ==========================================================
  // core_control settings
  // expected values come from the written data, not from the state copy
  pullup_follows_a: assert property (
    cc_take && state_r.ctrl.soft_reset |=>
      pullup_en_o == !$past(avs_writedata_i[`UFCC_CC_HOST_DISCONNECT]))
    else $error("pull-up does not follow disconnect setting");
  bus_reset_block_a: assert property (
    clk_en_i && state_r.ctrl.host_disconnect |=> !bus_reset_ok_o)
    else $error("bus reset accepted while disconnected");
  clock_stop_a: assert property (
    cc_take |=> clk_gate_en_o == !$past(avs_writedata_i[`UFCC_CC_USB_CLOCK_STOP]))
    else $error("usb clock does not follow stop setting");
  combined_clear_a: assert property (
    cc_take && !avs_writedata_i[`UFCC_CC_SOFT_RESET] &&
      !avs_writedata_i[`UFCC_CC_USB_CLOCK_STOP] |=> !core_reset_o && clk_gate_en_o)
    else $error("combined release of reset and clock stop refused");
  reserved_zero_a: assert property (
    !avs_waitrequest_o && avs_address_i == `UFCC_CORE_CONTROL_ADDR |->
      avs_readdata_o[`UFCC_CC_RESERVED] == 1'b0)
    else $error("reserved control bit read as one");
  power_source_a: assert property (
    cc_take && state_r.ctrl.soft_reset |=>
      self_powered_o == $past(avs_writedata_i[`UFCC_CC_POWER_SOURCE]))
    else $error("power source not reported as written");
  core_reset_write_a: assert property (
    cc_take |=> core_reset_o == $past(avs_writedata_i[`UFCC_CC_SOFT_RESET]))
    else $error("core reset does not follow soft reset write");
  soft_reset_a: assert property (
    state_r.ctrl.soft_reset |-> ##[0:1] core_reset_o)
    else $error("core reset missing under soft reset");

  // ==========================================================
  // interrupt data toggle
  // a soft reset write in the same cycle restarts the pid, so it is excluded
  toggle_hold_a: assert property (
    clk_en_i && intr_done_i && !intr_ok_i && !state_r.ctrl.toggle_mode_select &&
      !core_reset_o && !state_r.ctrl.soft_reset && !cc_take |=> $stable(intr_toggle_o))
    else $error("pid toggled after failed transfer");
  toggle_flip_a: assert property (
    clk_en_i && intr_done_i && (intr_ok_i || state_r.ctrl.toggle_mode_select) &&
      !state_r.ctrl.soft_reset && !cc_take |=> intr_toggle_o != $past(intr_toggle_o))
    else $error("pid not toggled after transfer");

  // ==========================================================
  // bus answers and read-back
  ep0_rmw_zero_a: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[`UFCC_EP0_STALL] == 1'b0)
    else $error("ep0 stall read back as one");
  bus_answer_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i |=> !avs_waitrequest_o)
    else $error("bus answer late");

  // ==========================================================
  // endpoint stalls and packet size
  ep0_stall_set_a: assert property (
    ep_take && avs_byteenable_i[1] && avs_writedata_i[`UFCC_EP0_STALL] |=> ep0_stall_o)
    else $error("ep0 stall write of one ignored");
  ep0_setup_clr_a: assert property (
    clk_en_i && state_r.ep0_stall_sent && ep0_setup_rx_i &&
      !(avs_write_i && avs_waitrequest_o) |=> !state_r.ep0_stall)
    else $error("ep0 stall not cleared by setup");
  ep0_size_a: assert property (
    ep_take && avs_byteenable_i[0] && state_r.ctrl.soft_reset && state_r.buf_init_ep0 |=>
      ep0_max_packet_o == $past(avs_writedata_i[`UFCC_EP0_PKS_MSB:0]))
    else $error("ep0 packet size not taken");
  autoclr_keep_a: assert property (
    !state_r.ctrl.stall_auto_clear_select &&
      state_r.epn_stall[5] && !epn_stall_clr_i[5] |=> state_r.epn_stall[5])
    else $error("ep5 stall cleared without software");
  autoclr_release_a: assert property (
    clk_en_i && state_r.ctrl.stall_auto_clear_select && clear_feature_i &&
      clear_feature_ep_i == 3'h3 && !epn_stall_set_i[3] |=> !epn_stall_o[3])
    else $error("ep3 stall not released by clear feature");

  cfg_write_c: cover property (avs_write_i && !avs_waitrequest_o);
  ep0_release_c: cover property (state_r.ep0_stall ##[1:20] !state_r.ep0_stall);
  autoclr_c: cover property (state_r.ctrl.stall_auto_clear_select && clear_feature_i);
  toggle_c: cover property (intr_done_i && state_r.ctrl.toggle_mode_select);
  size_write_c: cover property (ep_take && state_r.buf_init_ep0);

endmodule
`default_nettype wire

// ### hdl/ufcc_pkg.sv
// types shared by the usb function core control block
package ufcc_pkg;

  // ==========================================================
  // bus slave states
  typedef enum logic [1:0] {
    UFCC_BUS_IDLE = 2'b00,
    UFCC_BUS_ANSWER = 2'b01
  } ufcc_bus_e;

  // ==========================================================
  // control settings held by software
  typedef struct packed {
    logic soft_reset;
    logic host_disconnect;
    logic usb_clock_stop;
    logic stall_auto_clear_select;
    logic toggle_mode_select;
    logic power_source_select;
  } ufcc_ctrl_s;

  // ==========================================================
  // all state of the block
  typedef struct packed {
    ufcc_bus_e bus;
    ufcc_ctrl_s ctrl;
    logic ep0_stall;
    logic ep0_stall_sent;
    logic [6:0] ep0_pks;
    logic [5:1] epn_stall;
    logic buf_init_ep0;
    logic [15:0] rdata;
    logic waitreq;
    logic pullup_en;
    logic clk_gate_en;
    logic core_reset;
    logic bus_reset_ok;
    logic ep0_stall_active;
    logic [5:1] epn_stall_active;
    logic intr_toggle;
    logic self_powered;
  } ufcc_state_s;

endpackage

// ### hdl/ufcc_regs.svh
// register offsets, field positions, reset values and size limit of the control block
`ifndef UFCC_REGS_SVH
`define UFCC_REGS_SVH

// byte addresses on the avalon word bus
`define UFCC_CORE_CONTROL_ADDR 4'h0
`define UFCC_EP_ZERO_CONTROL_ADDR 4'h4
`define UFCC_BUF_INIT_ADDR 4'h8

// core_control fields
`define UFCC_CC_SOFT_RESET 7
`define UFCC_CC_HOST_DISCONNECT 5
`define UFCC_CC_USB_CLOCK_STOP 4
`define UFCC_CC_STALL_AUTO_CLEAR 3
`define UFCC_CC_RESERVED 2
`define UFCC_CC_TOGGLE_MODE 1
`define UFCC_CC_POWER_SOURCE 0

// endpoint_zero_control fields
`define UFCC_EP0_STALL 9
`define UFCC_EP0_PKS_MSB 6

// reset value and packet size limit
`define UFCC_EP0_PKS_RESET 7'h40
`define UFCC_EP0_PKS_MAX 7'h40

// buf_init register fields
`define UFCC_BI_EP0 0

`endif

// ### test/testbench.sv
// self-checking bench of the usb function control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst = 1'b1; // chip reset held at start
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata; // last read answer
  logic [5:1] sset = 5'h00; // software stall set
  logic [5:1] sclr = 5'h00; // software stall release
  logic [31:0] rdo;
  logic wreq, pu, cg, cr, bro, e0s, tg, sp;
  logic [5:1] ens;
  logic [6:0] mp;
  logic br, ss, su, cf, idn, iok;
  logic [2:0] cfe;
  int errors = 0;
  int check_count = 0;

  always #12.5 sys_clk = ~sys_clk;

  ufcc_host_model host (.clk_i(sys_clk), .bus_reset_o(br), .stall_sent_o(ss),
    .setup_o(su), .clr_feat_o(cf), .clr_ep_o(cfe), .intr_done_o(idn), .intr_ok_o(iok));

  // clk_en_i is the only tied input
  ufcc_core dut (.sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(1'b1),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wreq),
    .usb_bus_reset_i(br), .ep0_stall_sent_i(ss), .ep0_setup_rx_i(su),
    .clear_feature_i(cf), .clear_feature_ep_i(cfe), .epn_stall_set_i(sset),
    .epn_stall_clr_i(sclr), .intr_done_i(idn), .intr_ok_i(iok), .pullup_en_o(pu),
    .clk_gate_en_o(cg), .core_reset_o(cr), .bus_reset_ok_o(bro), .ep0_stall_o(e0s),
    .epn_stall_o(ens), .intr_toggle_o(tg), .self_powered_o(sp), .ep0_max_packet_o(mp));

  // ==========================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // avalon cycle: request held until the edge at which waitrequest is low
  // waitrequest is looked at mid-cycle, where it is settled for the next edge;
  // only the watchdog ends a wait that never gets an answer
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    addr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    @(negedge sys_clk);
    while (wreq !== 1'b0) begin
      @(negedge sys_clk);
    end
    rdata = rdo; // read data stands through the coming answer edge
    @(posedge sys_clk); // answer edge: the transfer completes here
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk); // idle edge keeps drivers single per step
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rdata, exp);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    rdc(4'h0, 32'h000000A0);
    chk(cr, 1'b1);
    chk(pu, 1'b0);
    rdc(4'h4, 32'h00000040);
    rdc(4'h8, 32'h00000001);
    rdc(4'hC, 32'h0); // unmapped place reads zero
    host.send(5'h10, 3'h0, 1'b0);
    @(posedge sys_clk);
    chk(bro, 1'b0);
    bus(1'b1, 4'h0, 32'h8B, 4'h1);
    chk(pu, 1'b1);
    chk(sp, 1'b1);
    rdc(4'h0, 32'h0000008B);
    // undefined top nibble set, stall written 0
    bus(1'b1, 4'h4, 32'hF008, 4'h3);
    rdc(4'h4, 32'h00000008);
    chk(mp, 7'h08);
  endtask

  // released, auto clear and unconditional toggle on
  task automatic t_run;
    bus(1'b1, 4'h0, 32'h0B, 4'h1);
    chk(cr, 1'b0);
    bus(1'b1, 4'h8, 32'h0, 4'h1);
    host.send(5'h10, 3'h0, 1'b0);
    @(negedge sys_clk); // the accept pulse stands for one cycle only
    chk(bro, 1'b1);
    host.send(5'h01, 3'h0, 1'b0); // failed transfer
    @(posedge sys_clk);
    chk(tg, 1'b1);
    chk(bro, 1'b0); // accept pulse is over
    sset <= 5'h04;
    @(posedge sys_clk);
    sset <= 5'h00;
    @(posedge sys_clk);
    chk(ens, 5'h04);
    host.send(5'h02, 3'h2, 1'b0); // other endpoint named
    @(posedge sys_clk);
    chk(ens, 5'h04);
    host.send(5'h02, 3'h3, 1'b0);
    @(posedge sys_clk);
    chk(ens, 5'h00);
  endtask

  task automatic t_ep0;
    bus(1'b1, 4'h4, 32'h0200, 4'h2);
    chk(e0s, 1'b1);
    rdc(4'h4, 32'h00000008);
    bus(1'b1, 4'h4, 32'h0, 4'h2);
    chk(e0s, 1'b1);
    host.send(5'h04, 3'h0, 1'b0); // setup before any stall sent
    @(posedge sys_clk);
    chk(e0s, 1'b1);
    host.send(5'h08, 3'h0, 1'b0);
    host.send(5'h04, 3'h0, 1'b0);
    @(posedge sys_clk);
    chk(e0s, 1'b0);
  endtask

  // second soft reset: clock stop, success-only toggle, software release
  task automatic t_mode0;
    bus(1'b1, 4'h0, 32'h80, 4'h1);
    chk(cr, 1'b1);
    repeat (3) @(posedge sys_clk);
    bus(1'b1, 4'h0, 32'h90, 4'h1);
    chk(cg, 1'b0);
    chk(sp, 1'b0);
    rdc(4'h0, 32'h00000090);
    bus(1'b1, 4'h0, 32'h00, 4'h1);
    chk(cg, 1'b1);
    chk(cr, 1'b0);
    host.send(5'h01, 3'h0, 1'b0);
    @(posedge sys_clk);
    chk(tg, 1'b0);
    host.send(5'h01, 3'h0, 1'b1);
    @(posedge sys_clk);
    chk(tg, 1'b1);
    sset <= 5'h10;
    @(posedge sys_clk);
    sset <= 5'h00;
    host.send(5'h02, 3'h5, 1'b0);
    @(posedge sys_clk);
    chk(ens, 5'h10);
    sclr <= 5'h10;
    @(posedge sys_clk);
    sclr <= 5'h00;
    @(posedge sys_clk);
    chk(ens, 5'h00);
  endtask

  // ==========================================
  // verdict and run control
  task automatic conclude;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // whole run is just over a hundred cycles; the 3000-cycle limit is generous
  initial begin
    #(25 * 3000);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_run();
    t_ep0();
    t_mode0();
    conclude();
  end
endmodule
`default_nettype wire

// ### test/ufcc_host_model.sv
// usb host or hub model: bus events seen by the control block
`timescale 1ns/1ps
`default_nettype none
module ufcc_host_model (
  input wire logic clk_i,
  output logic bus_reset_o,
  output logic stall_sent_o,
  output logic setup_o,
  output logic clr_feat_o,
  output logic [2:0] clr_ep_o,
  output logic intr_done_o,
  output logic intr_ok_o
);
  // ==========================================
  // idle levels
  initial begin
    {bus_reset_o, stall_sent_o, setup_o, clr_feat_o, intr_done_o} = 5'h00;
    clr_ep_o = 3'h7; // no endpoint named
    intr_ok_o = 1'b0;
  end

  // ==========================================
  // one event cycle
  // m: bus reset, stall sent, setup, clear feature, transfer end
  // qualifiers flip afterwards so stale values never look valid
  task automatic send(input logic [4:0] m, input logic [2:0] ep, input logic ok);
    @(posedge clk_i);
    {bus_reset_o, stall_sent_o, setup_o, clr_feat_o, intr_done_o} <= m;
    clr_ep_o <= ep;
    intr_ok_o <= ok;
    @(posedge clk_i);
    {bus_reset_o, stall_sent_o, setup_o, clr_feat_o, intr_done_o} <= 5'h00;
    clr_ep_o <= ~ep;
    intr_ok_o <= ~ok;
  endtask
endmodule
`default_nettype wire
